//--- core/bep_pkg.sv
package bep_pkg;

  // System clock and serial framing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CMD_BITS = 8;
  localparam int STATUS_BITS = 16;
  localparam int MSG_BITS = 12;
  localparam int CRC_BITS = 4;
  localparam int BALANCERS = 6;

  // Delayed start after resume or a new command
  localparam int DELAYED_START_TIME_NS = 2000000;
  localparam int DELAYED_START_CYCLES =
    (DELAYED_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Command byte: seven code bits, then an even parity bit
  localparam logic [6:0] CMD_EXECUTE = 7'h57;
  localparam logic [6:0] CMD_READ_STATUS = 7'h55;

  // Status word layout and reset value
  localparam logic [CRC_BITS-1:0] CRC_POLY = 4'h3;
  localparam logic [CRC_BITS-1:0] CRC_INVERT = 4'hf;
  localparam logic [STATUS_BITS-1:0] STATUS_RESET = 16'h000f;
  localparam int STATUS_GATE_MSB = 15;
  localparam int STATUS_CELLS_POS = 9;
  localparam int STATUS_SEC_POS = 8;
  localparam int STATUS_TEMP_POS = 7;

  typedef struct packed {
    logic [BALANCERS-1:0] gate_drive_ok;
    logic cells_not_overvoltage;
    logic secondary_not_overvoltage;
    logic temp_ok;
  } bep_flags_s;

  typedef struct packed {
    logic chip_select_n;
    logic serial_clock;
    logic serial_data;
  } bep_serial_s;

  typedef enum logic [1:0] {
    PORT_IDLE,
    PORT_CMD,
    PORT_IGNORE,
    PORT_STATUS
  } bep_port_e;

  typedef enum logic [1:0] {
    BAL_OFF,
    BAL_WAIT,
    BAL_ON,
    BAL_PAUSED
  } bep_bal_e;

endpackage : bep_pkg

//--- core/bep_status_word.sv
`timescale 1ns/10ps
module bep_status_word
  import bep_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Message
  input wire logic [MSG_BITS-1:0] message_in,
  // Word with check bits
  output logic [STATUS_BITS-1:0] status_word_out
);

  logic [STATUS_BITS-1:0] next_status_word;

  // CRC-4 x4+x+1 over the message, MSB first, sent inverted
  always_comb begin
    logic [CRC_BITS-1:0] crc;
    logic fb;
    crc = '0;
    fb = 1'b0;
    for (int i = MSG_BITS - 1; i >= 0; i--) begin
      fb = crc[CRC_BITS-1] ^ message_in[i];
      crc = {crc[CRC_BITS-2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end
    next_status_word = {message_in, crc ^ CRC_INVERT};
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      status_word_out <= STATUS_RESET;
    end else if (clk_en_in) begin
      status_word_out <= next_status_word;
    end
  end

endmodule : bep_status_word

//--- core/bep_balance_ctrl.sv
`timescale 1ns/10ps
// Behaviour
// - Execute starts latched balance command after the delayed start time
// - After execute, ignore data until reselect
// - Inverted-parity execute pauses, keeps stored command
// - Correct-parity execute resumes stored command
// - Any bad-parity command byte pauses balancing
// - Restart after delayed start time from eighth edge
// - Status word order: gates, flags, zeros, CRC
// - Reset status word reads 0x000f
// - Inverted CRC-4 x4+x+1 over twelve bits
// - Gate-drive flag high only for active balancer
module bep_balance_ctrl
  import bep_pkg::*;
#(
  parameter int START_CYCLES = DELAYED_START_CYCLES
) (
  // Clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // Serial port pins
  input wire bep_serial_s serial_in,
  output logic serial_data_out,
  // Latched balance command from the write path
  input wire logic [MSG_BITS-1:0] latched_cmd_in,
  input wire logic latched_valid_in,
  // Analog fault comparators
  input wire bep_flags_s flags_in,
  // Balancer drive and state
  output logic [MSG_BITS-1:0] balance_drive_out,
  output logic paused_out,
  output logic [STATUS_BITS-1:0] status_word_out
);

  localparam int CW = $clog2(START_CYCLES + 1);

  // A zero delay would make the counter width CW zero
  if (START_CYCLES < 1) begin : g_bad_start
    $error("START_CYCLES must be at least one");
  end

  // Two-stage synchronisers; stage one feeds only stage two
  bep_serial_s pin_s1, pin_s2, pin_s3;
  bep_flags_s flag_s1, flag_s2;

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1 <= '{chip_select_n: 1'b1, serial_clock: 1'b0, serial_data: 1'b0};
      pin_s2 <= '{chip_select_n: 1'b1, serial_clock: 1'b0, serial_data: 1'b0};
      pin_s3 <= '{chip_select_n: 1'b1, serial_clock: 1'b0, serial_data: 1'b0};
      flag_s1 <= '0;
      flag_s2 <= '0;
    end else if (clk_en_in) begin
      pin_s1 <= serial_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      flag_s1 <= flags_in;
      flag_s2 <= flag_s1;
    end
  end

  logic sck_rise, sck_fall, cs_low;
  assign sck_rise = pin_s2.serial_clock & ~pin_s3.serial_clock;
  assign sck_fall = ~pin_s2.serial_clock & pin_s3.serial_clock;
  assign cs_low = ~pin_s2.chip_select_n;

  // Serial port state
  bep_port_e port_state, next_port_state;
  logic [CMD_BITS-1:0] shift, next_shift;
  logic [4:0] bit_cnt, next_bit_cnt;
  logic [STATUS_BITS-1:0] out_shift, next_out_shift;
  logic next_serial_data;
  logic cmd_done, parity_ok, is_execute;
  logic [CMD_BITS-1:0] full_byte;

  assign full_byte = {shift[CMD_BITS-2:0], pin_s2.serial_data};
  assign parity_ok = ~(^full_byte);
  assign is_execute = full_byte[CMD_BITS-1:1] == CMD_EXECUTE;
  assign cmd_done = (port_state == PORT_CMD) && cs_low && sck_rise
                    && (bit_cnt == 5'(CMD_BITS - 1));

  always_comb begin
    next_port_state = port_state;
    next_shift = shift;
    next_bit_cnt = bit_cnt;
    next_out_shift = out_shift;
    next_serial_data = serial_data_out;
    case (port_state)
      PORT_IDLE: begin
        next_bit_cnt = '0;
        if (cs_low) begin
          next_port_state = PORT_CMD;
        end
      end
      PORT_CMD: begin
        if (!cs_low) begin
          next_port_state = PORT_IDLE;
        end else if (sck_rise) begin
          next_shift = full_byte;
          next_bit_cnt = bit_cnt + 5'h1;
          if (cmd_done) begin
            next_bit_cnt = '0;
            if (parity_ok && full_byte[CMD_BITS-1:1] == CMD_READ_STATUS) begin
              next_port_state = PORT_STATUS;
              next_out_shift = status_word_out;
            end else begin
              next_port_state = PORT_IGNORE;
            end
          end
        end
      end
      PORT_STATUS: begin
        if (!cs_low) begin
          next_port_state = PORT_IDLE;
          next_serial_data = 1'b0;
        end else if (sck_fall) begin
          // MSB first; word repeats if the host keeps clocking
          next_serial_data = out_shift[STATUS_BITS-1];
          next_out_shift = {out_shift[STATUS_BITS-2:0], out_shift[STATUS_BITS-1]};
        end
      end
      default: begin
        // Data after the command byte is dropped until reselect
        if (!cs_low) begin
          next_port_state = PORT_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      port_state <= PORT_IDLE;
      shift <= '0;
      bit_cnt <= '0;
      out_shift <= '0;
      serial_data_out <= 1'b0;
    end else if (clk_en_in) begin
      port_state <= next_port_state;
      shift <= next_shift;
      bit_cnt <= next_bit_cnt;
      out_shift <= next_out_shift;
      serial_data_out <= next_serial_data;
    end
  end

  // Balancing state
  bep_bal_e bal_state, next_bal_state;
  logic [MSG_BITS-1:0] running, next_running;
  logic [CW-1:0] delay_cnt, next_delay_cnt;
  logic [MSG_BITS-1:0] next_drive;

  always_comb begin
    next_bal_state = bal_state;
    next_running = running;
    next_delay_cnt = delay_cnt;
    if (cmd_done && !parity_ok) begin
      // Pausing keeps the stored command for a later resume
      if (bal_state != BAL_OFF) begin
        next_bal_state = BAL_PAUSED;
      end
    end else if (cmd_done && is_execute) begin
      if (bal_state == BAL_PAUSED) begin
        next_bal_state = BAL_WAIT;
        next_delay_cnt = CW'(START_CYCLES);
      end else if (!latched_valid_in || latched_cmd_in == '0) begin
        next_bal_state = BAL_OFF;
        next_running = '0;
      end else if (latched_cmd_in != running || bal_state == BAL_OFF) begin
        next_running = latched_cmd_in;
        next_bal_state = BAL_WAIT;
        next_delay_cnt = CW'(START_CYCLES);
      end
    end else if (bal_state == BAL_WAIT) begin
      if (delay_cnt <= CW'(1)) begin
        next_bal_state = BAL_ON;
        next_delay_cnt = '0;
      end else begin
        next_delay_cnt = delay_cnt - CW'(1);
      end
    end
    next_drive = (next_bal_state == BAL_ON) ? next_running : '0;
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      bal_state <= BAL_OFF;
      running <= '0;
      delay_cnt <= '0;
      balance_drive_out <= '0;
      paused_out <= 1'b0;
    end else if (clk_en_in) begin
      bal_state <= next_bal_state;
      running <= next_running;
      delay_cnt <= next_delay_cnt;
      balance_drive_out <= next_drive;
      paused_out <= next_bal_state == BAL_PAUSED;
    end
  end

  // Status message: flags shown only for balancers that are running
  logic [BALANCERS-1:0] active;
  logic [MSG_BITS-1:0] message;

  for (genvar n = 0; n < BALANCERS; n++) begin : g_act
    assign active[BALANCERS-1-n] = |balance_drive_out[MSG_BITS-1-2*n -: 2];
  end

  always_comb begin
    message = '0;
    message[STATUS_GATE_MSB-CRC_BITS -: BALANCERS] = flag_s2.gate_drive_ok & active;
    message[STATUS_CELLS_POS-CRC_BITS] = flag_s2.cells_not_overvoltage & |active;
    message[STATUS_SEC_POS-CRC_BITS] = flag_s2.secondary_not_overvoltage & |active;
    message[STATUS_TEMP_POS-CRC_BITS] = flag_s2.temp_ok & |active;
  end

  bep_status_word u_status (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .message_in(message),
    .status_word_out(status_word_out)
  );

endmodule : bep_balance_ctrl

//--- tb/bep_balance_chk.sv
`timescale 1ns/10ps
module bep_balance_chk
  import bep_pkg::*;
#(
  parameter int START_CYCLES = DELAYED_START_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Watched ports
  input wire logic [MSG_BITS-1:0] latched_cmd_in,
  input wire logic [MSG_BITS-1:0] balance_drive_out,
  input wire logic paused_out,
  input wire logic [STATUS_BITS-1:0] status_word_out
);
  logic [31:0] zero_cnt;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  function automatic logic [CRC_BITS-1:0] crc_of(input logic [MSG_BITS-1:0] m);
    logic [CRC_BITS-1:0] r;
    r = '0;
    for (int i = MSG_BITS - 1; i >= 0; i--) begin
      r = {r[2:0], 1'b0} ^ ((r[3] ^ m[i]) ? CRC_POLY : 4'h0);
    end
    return r ^ CRC_INVERT;
  endfunction : crc_of

  // Idle cycles seen before the drive comes on
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      zero_cnt <= 32'h0;
    end else begin
      zero_cnt <= (balance_drive_out != '0) ? 32'h0 : zero_cnt + 32'h1;
    end
  end

  a_reset_word: assert property ($fell(reset_in) |-> status_word_out == STATUS_RESET)
    else $error("status word not at reset value");
  a_unused_zero: assert property (status_word_out[6:4] == 3'h0)
    else $error("unused status bits set");
  a_status_crc: assert property (status_word_out[3:0] == crc_of(status_word_out[15:4]))
    else $error("status check bits wrong");
  a_idle_flags: assert property ((balance_drive_out == '0) [*4] |=>
    status_word_out[15:7] == 9'h000) else $error("flag high while idle");
  a_pause_off: assert property (paused_out |-> balance_drive_out == '0)
    else $error("drive on while paused");
  a_start_delay: assert property (balance_drive_out != '0 && $past(balance_drive_out) == '0
    |-> zero_cnt >= START_CYCLES) else $error("start came early");
  a_drive_cmd: assert property (balance_drive_out != '0 |-> balance_drive_out == latched_cmd_in)
    else $error("drive differs from latched command");
  a_resume_wait: assert property ($fell(paused_out) |-> balance_drive_out == '0)
    else $error("resume skipped the delay");
  cover property ($rose(paused_out));
  cover property ($fell(paused_out));
  cover property ($rose(balance_drive_out != '0));
endmodule : bep_balance_chk

bind bep_balance_ctrl bep_balance_chk #(.START_CYCLES(START_CYCLES)) chk (
  .clk_sys_in(clk_sys_in), .reset_in(reset_in), .latched_cmd_in(latched_cmd_in),
  .balance_drive_out(balance_drive_out), .paused_out(paused_out),
  .status_word_out(status_word_out));

//--- tb/bep_host.sv
`timescale 1ns/10ps
module bep_host
  import bep_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Port pins and returned data
  output bep_serial_s pins_out,
  input wire logic data_in
);
  logic [15:0] word;
  initial pins_out = '{1'b1, 1'b0, 1'b1};

  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask : tick

  // Clock stands low between frames
  task automatic send(input logic [7:0] b, input bit keep, input bit rd);
    pins_out.chip_select_n = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      pins_out.serial_data = b[i];
      tick(4);
      pins_out.serial_clock = 1'b1;
      tick(4);
      pins_out.serial_clock = 1'b0;
    end
    tick(4);
    for (int i = 0; i < 16 && rd; i++) begin
      pins_out.serial_clock = 1'b1;
      tick(2);
      word = {word[14:0], data_in};
      tick(2);
      pins_out.serial_clock = 1'b0;
      tick(4);
    end
    if (!keep) begin
      pins_out.chip_select_n = 1'b1;
      pins_out.serial_data = ~pins_out.serial_data;
      tick(4);
    end
  endtask : send
endmodule : bep_host

//--- tb/test_balance_execute_pause_status.sv
`timescale 1ns/10ps
module test_balance_execute_pause_status
  import bep_pkg::*;
;
  localparam int SC = 100;
  localparam logic [11:0] CMD = 12'h830;
  logic clk_sys_in;
  logic reset_in;
  logic sdo;
  logic paused;
  logic [11:0] drive;
  logic [15:0] status;
  logic valid;
  bep_serial_s pins;
  int mismatches;
  int samples_checked;
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

  bep_balance_ctrl #(.START_CYCLES(SC)) uut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .clk_en_in(1'b1), .serial_in(pins), .serial_data_out(sdo), .latched_cmd_in(CMD),
    .latched_valid_in(valid), .flags_in(9'h1ff), .balance_drive_out(drive),
    .paused_out(paused), .status_word_out(status));
  bep_host host (.clk_in(clk_sys_in), .pins_out(pins), .data_in(sdo));

  initial begin
    clk_sys_in = 1'b0;
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  // Cycles counted from the eighth rising serial clock
  task automatic wait_on(input int n);
    `CHK(drive, 12'h000)
    while (drive === 12'h000 && n < 3 * SC) begin
      @(negedge clk_sys_in);
      n++;
    end
    `CHK(n >= SC && n <= SC + 6, 1'b1)
    `CHK(drive, CMD)
  endtask : wait_on

  task automatic t_exec();
    host.send(8'haf, 1'b1, 1'b0);
    wait_on(8);
    host.send(8'hae, 1'b0, 1'b0);
    `CHK(paused, 1'b0)
    `CHK(drive, CMD)
  endtask : t_exec

  // Balancers 1 and 4 active, all flags good
  task automatic t_status();
    host.send(8'haa, 1'b0, 1'b1);
    `CHK(host.word, 16'h9385)
    `CHK(status, 16'h9385)
  endtask : t_status

  task automatic t_pause();
    logic [6:0] code;
    for (int c = 0; c < 4; c++) begin
      code = {5'b10101, c[1:0]};
      host.send({code, ~^code}, 1'b0, 1'b0);
      `CHK(paused, 1'b1)
      `CHK(drive, 12'h000)
      host.send(8'haf, 1'b0, 1'b0);
      `CHK(paused, 1'b0)
      wait_on(12);
    end
  endtask : t_pause

  // Execute with no valid latched command stops balancing
  task automatic t_off();
    valid = 1'b0;
    host.send(8'haf, 1'b0, 1'b0);
    `CHK(drive, 12'h000)
    `CHK(paused, 1'b0)
    `CHK(status, 16'h000f)
  endtask : t_off

  task automatic results();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  initial begin
    mismatches = 0;
    samples_checked = 0;
    valid = 1'b1;
    reset_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    reset_in = 1'b0;
    host.tick(2);
    `CHK(status, 16'h000f)
    `CHK(drive, 12'h000)
    t_exec();
    t_status();
    t_pause();
    t_off();
    results();
  end

  initial begin
    #(50 * SC * 100);
    mismatches++;
    results();
  end
endmodule : test_balance_execute_pause_status
